// ### rmb_pkg.sv
// rmb_pkg: shared constants for the multiplexed host bus port
// assumes: both ends run on one 10 MHz clock and import this package
package rmb_pkg;
  localparam int unsigned RMB_DATA_W = 8;
  localparam int unsigned RMB_ADDR_W = 7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned RMB_CLK_PERIOD_NS = 100;
  // strobe phase base length; the host end holds each phase one clock longer
  localparam int unsigned RMB_PHASE_NS = 300;
  localparam int unsigned RMB_PHASE_CYC =
    (RMB_PHASE_NS + RMB_CLK_PERIOD_NS - 1) / RMB_CLK_PERIOD_NS;
  localparam logic [3:0] RMB_PHASE_CNT = 4'(RMB_PHASE_CYC);
  localparam logic [RMB_ADDR_W-1:0] RMB_ADDR_RST = 7'h00;
  localparam logic [RMB_DATA_W-1:0] RMB_DATA_RST = 8'h00;
  // levels the pin synchronisers reset to: strobes, select and write enable idle,
  // supply good, reset released
  localparam logic [6:0] RMB_PIN_IDLE = 7'h4E;
  // strap is loaded on the third edge after release, once both its flops hold the pin
  localparam logic [1:0] RMB_STRAP_LOAD = 2'h2;
  // external oscillator rate accepted on osc_input
  localparam int unsigned RMB_OSC_HZ = 32768;
  localparam int unsigned RMB_MEM_DEPTH = 128;
endpackage : rmb_pkg

// ### rmb_if.sv
// rmb_if: multiplexed byte bus wires between host and device ends
// assumes: testbench resolves the shared bus from the two enables
`timescale 1ns/1ps
interface rmb_if;
  import rmb_pkg::*;
  logic bus_style_select;
  logic address_latch_strobe;
  logic data_strobe;
  logic rw_n;
  logic cs_n;
  logic [RMB_DATA_W-1:0] host_bus_out;
  logic host_bus_oe;
  logic [RMB_DATA_W-1:0] dev_bus_out;
  logic dev_bus_oe;
  logic [RMB_DATA_W-1:0] muxed_addr_data_bus;
  modport dev (
    input bus_style_select, address_latch_strobe, data_strobe, rw_n, cs_n,
    input muxed_addr_data_bus,
    output dev_bus_out, dev_bus_oe
  );
  modport host (
    output bus_style_select, address_latch_strobe, data_strobe, rw_n, cs_n,
    output host_bus_out, host_bus_oe,
    input muxed_addr_data_bus
  );
endinterface : rmb_if

// ### rmb_dev.sv
// rmb_dev: device end of the multiplexed host bus port with a 128-byte store
// assumes: bus pins arrive asynchronously; supply monitor and reset are levels
//
// Summary of operation
// - strap high: level direction, else split strobes
// - latch address on address strobe fall
// - write data on strobe fall or write rise
// - drive bus in each mode's read window
// - release bus at end of read window
// - access only with select; address always latched
// - host holds select through strobes
// - below power-fail threshold, select forced inactive
// - clear latched address on address strobe rise
// - host strobes address before each access
// - host re-strobes address after deselected access
// - level mode: high is read, low write
// - split mode: pin is active-low write enable
// - external oscillator input accepted, output unused
// - reset low blocks all accesses
`timescale 1ns/1ps
module rmb_dev
  import rmb_pkg::*;
#(
  parameter int unsigned DEPTH = RMB_MEM_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  rmb_if.dev bus,
  input wire logic power_fail,
  input wire logic host_reset_n,
  input wire logic osc_input,
  output logic osc_output,
  output logic osc_tick
);
  import rmb_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NS = 7;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  // the bus byte runs in step with the strobes; its third stage is the byte
  // that stood before the edge that the strobe flops have just seen
  logic [RMB_DATA_W-1:0] d1_r;
  logic [RMB_DATA_W-1:0] d2_r;
  logic [RMB_DATA_W-1:0] d3_r;
  logic [1:0] o1_r;
  // supply and reset levels pass their own flops before they are combined
  assign raw = {host_reset_n, osc_input, power_fail, bus.cs_n, bus.rw_n,
                bus.data_strobe, bus.address_latch_strobe};

  // split-style idle levels; a false level-style fall after reset finds nothing armed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RMB_PIN_IDLE;
      s2_r <= RMB_PIN_IDLE;
      s3_r <= RMB_PIN_IDLE;
      d1_r <= RMB_DATA_RST;
      d2_r <= RMB_DATA_RST;
      d3_r <= RMB_DATA_RST;
      o1_r <= 2'h0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= bus.muxed_addr_data_bus;
      d2_r <= d1_r;
      d3_r <= d2_r;
      o1_r <= {o1_r[0], s2_r[5]};
    end
  end

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic as_q, ds_q, rw_q, cs_q, blk_q, mot_r;
  assign as_q = s2_r[0];
  assign ds_q = s2_r[1];
  assign rw_q = s2_r[2];
  assign blk_q = s2_r[4] | ~s2_r[6];
  // power fail or reset forces select inactive
  assign cs_q = ~s2_r[3] & ~blk_q;
  logic as_fall, as_rise, ds_fall, ds_rise, rw_rise;
  assign as_fall = s3_r[0] & ~as_q;
  assign as_rise = ~s3_r[0] & as_q;
  assign ds_fall = s3_r[1] & ~ds_q;
  assign ds_rise = ~s3_r[1] & ds_q;
  assign rw_rise = ~s3_r[2] & rw_q;

  // ---------------------------------------------------------------
  // bus style strap
  // ---------------------------------------------------------------
  // two flops, then loaded once; the pin has a pulldown, so open reads split
  logic strap_s1_r, strap_s2_r, mot_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    mot_nxt = mot_r;
    if (strap_cnt_r != 2'h3)
      strap_cnt_nxt = strap_cnt_r + 2'h1;
    if (strap_cnt_r == RMB_STRAP_LOAD)
      mot_nxt = strap_s2_r;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      strap_cnt_r <= 2'h0;
      mot_r <= 1'b0;
    end else begin
      strap_s1_r <= bus.bus_style_select;
      strap_s2_r <= strap_s1_r;
      strap_cnt_r <= strap_cnt_nxt;
      mot_r <= mot_nxt;
    end
  end

  // ---------------------------------------------------------------
  // address, write and read state
  // ---------------------------------------------------------------
  logic [RMB_DATA_W-1:0] mem [DEPTH];
  logic [RMB_ADDR_W-1:0] addr_r, addr_nxt;
  logic armed_r, armed_nxt;
  logic oe_r, oe_nxt;
  logic [RMB_DATA_W-1:0] dout_r, dout_nxt;
  logic wr_en;
  logic rd_win;

  always_comb begin
    addr_nxt = addr_r;
    armed_nxt = armed_r;
    wr_en = 1'b0;
    if (mot_r ? (ds_fall & ~rw_q) : rw_rise) begin
      wr_en = cs_q & armed_r;
      armed_nxt = 1'b0;
    end
    rd_win = mot_r ? (ds_q & rw_q) : (~ds_q & rw_q);
    // oe is registered, so the bus turns one clock after the window is seen
    oe_nxt = rd_win & cs_q & armed_r;
    // window ends on ds fall (level) or ds rise (split)
    if (mot_r ? ds_fall : ds_rise) begin
      oe_nxt = 1'b0;
      if (oe_r)
        armed_nxt = 1'b0;
    end
    // deselected read consumes the address too, so the host must strobe again
    if (~cs_q & armed_r & rw_q & (mot_r ? ds_fall : ds_rise))
      armed_nxt = 1'b0;
    // strobe edges come last: a fresh address outranks a clear in the same cycle
    if (as_rise) begin
      addr_nxt = RMB_ADDR_RST;
      armed_nxt = 1'b0;
    end else if (as_fall) begin
      // d3 still holds the bus as it stood while the strobe was high
      addr_nxt = d3_r[RMB_ADDR_W-1:0];
      armed_nxt = 1'b1;
    end
    dout_nxt = mem[addr_r];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= RMB_ADDR_RST;
      armed_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= RMB_DATA_RST;
    end else begin
      addr_r <= addr_nxt;
      armed_r <= armed_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
    end
  end

  // store has no reset: it stands for battery-backed contents
  always_ff @(posedge clk) begin
    if (wr_en)
      mem[addr_r] <= d3_r;
  end

  assign bus.dev_bus_out = dout_r;
  assign bus.dev_bus_oe = oe_r;

  // ---------------------------------------------------------------
  // oscillator input
  // ---------------------------------------------------------------
  logic tick_r, tick_nxt;
  // the oscillator is far slower than clk, so sampled edges never merge
  // one pulse per rising edge of the oscillator, one clock long
  always_comb begin
    tick_nxt = o1_r[0] & ~o1_r[1];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      tick_r <= 1'b0;
    else
      tick_r <= tick_nxt;
  end
  assign osc_tick = tick_r;
  // no crystal driver; output stays unused and low
  assign osc_output = 1'b0;
endmodule : rmb_dev

// ### rmb_host.sv
// rmb_host: host end issuing one strobed read or write per request
// assumes: same clock as the testbench; device answers within a phase
`timescale 1ns/1ps
module rmb_host
  import rmb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  rmb_if.host bus,
  input wire logic level_mode,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_select,
  input wire logic [RMB_ADDR_W-1:0] req_addr,
  input wire logic [RMB_DATA_W-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [RMB_DATA_W-1:0] rdata
);
  import rmb_pkg::*;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_ADDR = 3'b001, HS_GAP = 3'b011,
    HS_DATA = 3'b010, HS_END = 3'b110
  } rmb_hs_e;
  rmb_hs_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt, sel_r, sel_nxt, done_r, done_nxt;
  logic [RMB_DATA_W-1:0] a_r, a_nxt, rd_r, rd_nxt;
  logic [RMB_DATA_W-1:0] s1_r, s2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RMB_DATA_RST;
      s2_r <= RMB_DATA_RST;
    end else begin
      s1_r <= bus.muxed_addr_data_bus;
      s2_r <= s1_r;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r - 4'h1;
    wr_nxt = wr_r;
    sel_nxt = sel_r;
    a_nxt = a_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      HS_IDLE: begin
        cnt_nxt = RMB_PHASE_CNT;
        if (req) begin
          st_nxt = HS_ADDR;
          wr_nxt = req_write;
          sel_nxt = req_select;
          a_nxt = {1'b0, req_addr};
        end
      end
      HS_ADDR: if (cnt_r == 4'h0) begin
        st_nxt = HS_GAP;
        cnt_nxt = RMB_PHASE_CNT;
      end
      HS_GAP: if (cnt_r == 4'h0) begin
        st_nxt = HS_DATA;
        cnt_nxt = RMB_PHASE_CNT;
        if (wr_r)
          a_nxt = req_wdata;
      end
      HS_DATA: if (cnt_r == 4'h0) begin
        st_nxt = HS_END;
        cnt_nxt = RMB_PHASE_CNT;
      end
      HS_END: if (cnt_r == 4'h0) begin
        st_nxt = HS_IDLE;
        // the device answers through its synchronisers, so read data is
        // taken at the end of the cycle, well inside its drive window
        rd_nxt = s2_r;
        done_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= HS_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      sel_r <= 1'b0;
      a_r <= RMB_DATA_RST;
      rd_r <= RMB_DATA_RST;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      a_r <= a_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic act, dph;
  assign act = st_r != HS_IDLE;
  assign dph = st_r == HS_DATA;
  assign bus.bus_style_select = level_mode;
  assign bus.address_latch_strobe = st_r == HS_ADDR;
  // select held over whole cycle incl. address strobe
  assign bus.cs_n = ~(act & sel_r);
  // level mode ds high pulse with direction; split ds/rw low pulses
  assign bus.data_strobe = level_mode ? dph : ~(dph & ~wr_r);
  assign bus.rw_n = level_mode ? ~(act & wr_r) : ~(dph & wr_r);
  assign bus.host_bus_out = a_r;
  assign bus.host_bus_oe = (st_r == HS_ADDR) | (st_r == HS_GAP & ~wr_r) |
                           ((dph | st_r == HS_END) & wr_r);
  assign busy = act;
  assign done = done_r;
  assign rdata = rd_r;
endmodule : rmb_host

// ### rmb_assertions.sv
// rmb_assertions: timing checks on the wires joining host and device ends
// assumes: tb instantiates it beside the interface; one clock domain
`timescale 1ns/1ps
module rmb_assertions
  import rmb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_style_select,
  input wire logic address_latch_strobe,
  input wire logic data_strobe,
  input wire logic rw_n,
  input wire logic cs_n,
  input wire logic host_bus_oe,
  input wire logic dev_bus_oe,
  input wire logic power_fail,
  input wire logic host_reset_n
);
  logic act;
  logic [3:0] since_as_r;
  logic [3:0] since_as_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // split style counts the write enable as a strobe too
  assign act = bus_style_select ? data_strobe : !(data_strobe && rw_n);
  always_comb begin
    since_as_nxt = since_as_r;
    if (address_latch_strobe) begin
      since_as_nxt = 4'h0;
    end else if (since_as_r != 4'hF) begin
      since_as_nxt = since_as_r + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_as_r <= 4'hF;
    end else begin
      since_as_r <= since_as_nxt;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  no_clash_a: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("host and device drive the bus together");
  drive_window_a: assert property ($rose(dev_bus_oe) |-> $past(rw_n, 2) &&
    !$past(cs_n, 2) && $past(data_strobe, 2) == bus_style_select)
    else $error("device drove outside a read window");
  level_release_a: assert property (bus_style_select && $fell(data_strobe) |->
    ##[1:5] !dev_bus_oe) else $error("bus kept after strobe fall");
  split_release_a: assert property (!bus_style_select && $rose(data_strobe) |->
    ##[1:5] !dev_bus_oe) else $error("bus kept after strobe rise");
  deselect_quiet_a: assert property (cs_n [*5] |-> !dev_bus_oe)
    else $error("device drove while deselected");
  power_fail_a: assert property (power_fail [*5] |-> !dev_bus_oe)
    else $error("device drove below supply threshold");
  reset_block_a: assert property (!host_reset_n [*5] |-> !dev_bus_oe)
    else $error("device drove while held in reset");
  hold_select_a: assert property (act && $past(act) |-> $stable(cs_n))
    else $error("select moved during a strobe");
  fresh_addr_a: assert property ($rose(act) |-> since_as_r <= 4'h6)
    else $error("access without a fresh address strobe");
  addr_drive_a: assert property ($fell(address_latch_strobe) |->
    $past(host_bus_oe) && !dev_bus_oe) else $error("address not driven at latch");
  wdata_drive_a: assert property ((bus_style_select ? $fell(data_strobe) && !rw_n
    : $rose(rw_n)) |-> $past(host_bus_oe)) else $error("write data not driven");
  cover property ($rose(dev_bus_oe) && bus_style_select);
  cover property ($rose(dev_bus_oe) && !bus_style_select);
  cover property (power_fail && act);
endmodule : rmb_assertions

// ### tb.sv
// tb: random and corner accesses through both ends, data checked
// assumes: package, interface, both ends and checker compiled first
`timescale 1ns/1ps
module tb;
  import rmb_pkg::*;
  localparam int LIMIT = 20000;
  // oscillator half period in whole clock cycles, rounded to the nearest
  localparam int OSC_HALF =
    (500000000 / RMB_OSC_HZ + RMB_CLK_PERIOD_NS / 2) / RMB_CLK_PERIOD_NS;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic level_mode = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_select = 1'b0;
  logic [RMB_ADDR_W-1:0] req_addr = 7'h00;
  logic [RMB_DATA_W-1:0] req_wdata = 8'h00;
  logic power_fail = 1'b0;
  logic host_reset_n = 1'b1;
  logic osc_input = 1'b0;
  logic drove = 1'b0;
  logic osc_done = 1'b0;
  logic busy, done, osc_output, osc_tick;
  logic [RMB_DATA_W-1:0] rdata;
  logic [RMB_DATA_W-1:0] last_r = 8'h00;
  logic [RMB_DATA_W-1:0] mem [RMB_MEM_DEPTH];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int ticks = 0;
  integer seed = 32'hB712EB87;
  rmb_if bif();
  // a released bus shows the inverse of its last value, never a held copy
  assign bif.muxed_addr_data_bus = bif.host_bus_oe ? bif.host_bus_out :
    bif.dev_bus_oe ? bif.dev_bus_out : ~last_r;
  rmb_host rmb_host_i (.clk(clk), .nrst(nrst), .bus(bif), .level_mode(level_mode),
    .req(req), .req_write(req_write), .req_select(req_select), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
  rmb_dev rmb_dev_i (.clk(clk), .nrst(nrst), .bus(bif), .power_fail(power_fail),
    .host_reset_n(host_reset_n), .osc_input(osc_input), .osc_output(osc_output),
    .osc_tick(osc_tick));
  rmb_assertions rmb_assertions_i (.clk(clk), .nrst(nrst),
    .bus_style_select(bif.bus_style_select), .address_latch_strobe(bif.address_latch_strobe),
    .data_strobe(bif.data_strobe), .rw_n(bif.rw_n), .cs_n(bif.cs_n),
    .host_bus_oe(bif.host_bus_oe), .dev_bus_oe(bif.dev_bus_oe),
    .power_fail(power_fail), .host_reset_n(host_reset_n));
  // ---------------------------------------------------------------
  // clocks, monitors and checks
  // ---------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    wait (nrst === 1'b1 && level_mode === 1'b1);
    repeat (20) begin
      repeat (OSC_HALF) @(negedge clk);
      osc_input = ~osc_input;
    end
    osc_done = 1'b1;
  end
  always @(posedge clk) begin
    last_r <= bif.muxed_addr_data_bus;
    cyc <= cyc + 1;
    if (bif.dev_bus_oe === 1'b1) drove <= 1'b1;
    if (osc_tick === 1'b1) ticks <= ticks + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic ok_f(input logic s);
    return s && !power_fail && host_reset_n;
  endfunction : ok_f
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic acc(input logic w, input logic s, input logic [6:0] a, input logic [7:0] d);
    int k;
    req_write = w;
    req_select = s;
    req_addr = a;
    req_wdata = d;
    drove = 1'b0;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk1(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk1(done, 1'b1);
    chk1(busy, 1'b0);
    if (w && ok_f(s)) mem[a] = d;
  endtask : acc
  task automatic rd(input logic s, input logic [6:0] a);
    acc(1'b0, s, a, 8'h00);
    chk1(drove, ok_f(s));
    if (ok_f(s)) chk8(rdata, mem[a]);
  endtask : rd
  // ---------------------------------------------------------------
  // main sequence: each bus style needs its own reset for the strap
  // ---------------------------------------------------------------
  initial begin
    logic [6:0] wa;
    for (int m = 0; m < 2; m++) begin
      nrst = 1'b0;
      level_mode = m[0];
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      for (int a = 0; a < RMB_MEM_DEPTH; a++) acc(1'b1, 1'b1, a[6:0], 8'($random(seed)));
      repeat (20) rd(1'b1, 7'($random(seed)));
      for (int k = 0; k < 4; k++) begin
        wa = 7'($random(seed));
        power_fail = (k == 1);
        host_reset_n = (k != 2);
        repeat (4) @(negedge clk);
        acc(1'b1, k != 0, wa, ~mem[wa]);
        rd(k != 0, wa);
        power_fail = 1'b0;
        host_reset_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(1'b1, wa);
      end
    end
    wait (osc_done === 1'b1);
    repeat (5) @(negedge clk);
    chk8(8'(ticks), 8'h0A);
    chk1(osc_output, 1'b0);
    end_sim();
  end
endmodule : tb
